// file: core/adcrc_pkg.sv
package adcrc_pkg;

  // ----------------------------------------------------------------------
  // Clock and conversion timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int OSC60_HZ = 153_600;      // Internal clock, 60 Hz notch
  localparam int OSC50_HZ = OSC60_HZ * 50 / 60; // Same filter, 50 Hz notch
  localparam logic [9:0] OSC60_DIV = 10'(CLK_HZ / OSC60_HZ);
  localparam logic [9:0] OSC50_DIV = 10'(CLK_HZ / OSC50_HZ);
  localparam int CONV_RATIO = 20480;      // Conversion clocks per result
  localparam int FSEL_IDLE_NS = 100_000;  // No edge this long: pin is static
  localparam int FSEL_IDLE_CYC = FSEL_IDLE_NS / (1_000_000_000 / CLK_HZ);

  // ----------------------------------------------------------------------
  // Output word layout and coding
  // ----------------------------------------------------------------------
  localparam int WORD_BITS = 24;
  localparam int CODE_BITS = 20;
  localparam int RES_BITS = CODE_BITS + 2;  // Sign, range, code
  localparam int IN_BITS = 23;              // Signed input, 2^20 = reference
  localparam int FIFO_DEPTH = 32;
  localparam logic [4:0] LAST_FALL_IDX = 5'h17;  // Index of the 24th fall
  localparam logic [CODE_BITS-1:0] OVER_CLAMP = 20'h1ffff;
  localparam logic [CODE_BITS-1:0] UNDER_CLAMP = 20'he0000;
  localparam logic signed [IN_BITS-1:0] REF_IN = 23'sh100000;
  localparam logic signed [IN_BITS-1:0] OVER_IN = 23'sh11ffff;
  localparam logic signed [IN_BITS-1:0] UNDER_IN = 23'sh7e0000;

  typedef enum logic [0:0] {
    SER_IDLE = 1'b0,
    SER_SHIFT = 1'b1
  } adcrc_ser_t;

  // Returns {sign, range, code} for one signed input sample
  function automatic logic [RES_BITS-1:0] adcrc_code(
      input logic signed [IN_BITS-1:0] x);
    logic [IN_BITS-1:0] d;
    d = x - REF_IN;
    if (x >= OVER_IN)
      adcrc_code = {2'b11, OVER_CLAMP};          // [R8]
    else if (x >= REF_IN)
      adcrc_code = {2'b11, d[CODE_BITS-1:0]};    // [R8]
    else if (x >= 0)
      adcrc_code = {2'b10, x[CODE_BITS-1:0]};    // [R7] [R10]
    else if (x <= UNDER_IN)
      adcrc_code = {2'b01, UNDER_CLAMP};         // [R9]
    else
      adcrc_code = {2'b01, x[CODE_BITS-1:0]};    // [R9]
  endfunction

endpackage

// file: core/adcrc_top.sv
// Functional notes
// [R1] Internal clock 153.6 kHz gives 60 Hz notch and 7.5 results/s.
// [R2] Static select pin enables internal oscillator; low 60 Hz, high 50 Hz.
// [R3] A toggling select pin is the conversion clock; rate is it / 20480.
// [R4] Host may drive a fast clock, then hold the pin low again.
// [R5] Each result is independent of the one before.
// [R6] Word bits 23..20: done flag (low valid), zero, sign, range.
// [R7] Zero to reference: sign 1, range 0, straight binary code.
// [R8] Above reference: range 1, excess from zero, clamp 0x1ffff.
// [R9] Negative: sign 0, range 1, clamp 0xe0000 at -1/8 reference.
// [R10] Exactly zero: code zero, range 0, sign may read either way.
// [R11] Word is 24 bits, status first, MSB first.
// [R12] Chip select low outside readout shows the done flag on data out.
// [R13] One bit per clock fall; 24th fall drives out high, starts conversion.
// [R14] Chip select high floats data out; rise during readout aborts.
// [R15] An external conversion clock runs without gaps through a conversion.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------------
// Result FIFO
// ------------------------------------------------------------------------
module adcrc_fifo
  import adcrc_pkg::*;
#(
  parameter int WIDTH = RES_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Write side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Read side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } adcrc_fifo_t;

  adcrc_fifo_t s, n;
  logic push, pop;

  // Full and empty come straight from the occupancy count
  assign in_ready = (s.cnt != CW'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data = s.mem[s.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next state
  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wr] = in_data;
      n.wr = s.wr + AW'(1);
    end
    if (pop)
      n.rd = s.rd + AW'(1);
    n.cnt = s.cnt + CW'(push) - CW'(pop);
  end

  // State register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N)
      s <= '0;
    else
      s <= n;
  end
endmodule // adcrc_fifo

// ------------------------------------------------------------------------
// Rate control, result coding and serial port
// ------------------------------------------------------------------------
module adcrc_top
  import adcrc_pkg::*;
#(
  parameter int CONV_TICKS = CONV_RATIO,
  parameter int FSEL_IDLE_CYCLES = FSEL_IDLE_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Rate select pin and converted sample
  input wire logic RATE_SELECT_CLOCK_IN,
  input wire logic signed [IN_BITS-1:0] ANALOG_CODE,
  // Serial port
  input wire logic CS_N,
  input wire logic SCK,
  output logic SDO,
  output logic SDO_OE_N,
  // Status
  output logic EXT_CLOCK_MODE,
  output logic CONV_STALLED
);
  typedef struct packed {
    logic f0_s1;
    logic f0_s2;
    logic f0_d;
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic [15:0] idle_cnt;
    logic ext_mode;
    logic [9:0] osc_cnt;
    logic [14:0] tick_cnt;
    adcrc_ser_t state;
    logic [4:0] bit_cnt;
    logic [WORD_BITS-1:0] shreg;
    logic sdo;
    logic sdo_oe_n;
  } adcrc_state_t;

  localparam logic [14:0] CONV_DONE = 15'(CONV_TICKS);
  localparam logic [15:0] IDLE_LAST = 16'(FSEL_IDLE_CYCLES - 1);

  adcrc_state_t s, n;
  logic f0_edge, f0_rise, sck_fall, cs_low, cs_rise;
  logic [9:0] osc_div;
  logic conv_tick, push, push_ready, pop, restart;
  logic fifo_valid;
  logic [RES_BITS-1:0] fifo_data;
  logic [WORD_BITS-1:0] word;

  // Edges are taken from the second sync stage onward only
  assign f0_edge = s.f0_s2 ^ s.f0_d;
  assign f0_rise = s.f0_s2 & ~s.f0_d;
  assign sck_fall = ~s.sck_s2 & s.sck_d;
  assign cs_low = ~s.cs_s2;
  assign cs_rise = s.cs_s2 & ~s.cs_d;
  assign osc_div = s.f0_s2 ? OSC50_DIV : OSC60_DIV; // [R2]
  assign conv_tick = s.ext_mode ? f0_rise                   // [R3]
                                : (s.osc_cnt == osc_div - 10'h1); // [R1]
  assign push = (s.tick_cnt == CONV_DONE) && push_ready;
  assign word = {1'b0, 1'b0, fifo_data};  // [R6] [R11]

  adcrc_fifo #(
    .WIDTH(RES_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .in_valid(s.tick_cnt == CONV_DONE),
    .in_ready(push_ready),
    .in_data(adcrc_code(ANALOG_CODE)),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // Next state: clock select, conversion timing, serial shifter
  always_comb begin
    n = s;
    pop = 1'b0;
    restart = 1'b0;
    n.f0_s1 = RATE_SELECT_CLOCK_IN;
    n.f0_s2 = s.f0_s1;
    n.f0_d = s.f0_s2;
    n.cs_s1 = CS_N;
    n.cs_s2 = s.cs_s1;
    n.cs_d = s.cs_s2;
    n.sck_s1 = SCK;
    n.sck_s2 = s.sck_s1;
    n.sck_d = s.sck_s2;
    // A pin that stops toggling hands back to the oscillator
    if (f0_edge) begin
      n.idle_cnt = '0;
      n.ext_mode = 1'b1;  // [R3]
    end else if (s.idle_cnt == IDLE_LAST) begin
      n.ext_mode = 1'b0;  // [R2] [R4]
    end else begin
      n.idle_cnt = s.idle_cnt + 16'h1;
    end
    n.osc_cnt = (s.osc_cnt >= osc_div - 10'h1) ? '0 : s.osc_cnt + 10'h1;
    // Serial port; clock falls are ignored while chip select is high
    n.sdo_oe_n = s.cs_s2;  // [R14]
    case (s.state)
      SER_IDLE: begin
        n.sdo = ~fifo_valid;  // [R12]
        if (cs_low && sck_fall && fifo_valid) begin
          n.sdo = word[WORD_BITS-2];  // [R13]
          n.shreg = {word[WORD_BITS-3:0], 2'b11};
          n.bit_cnt = 5'h1;
          n.state = SER_SHIFT;
        end
      end
      SER_SHIFT: begin
        if (cs_rise) begin
          pop = 1'b1;  // [R14]
          restart = 1'b1;
          n.state = SER_IDLE;
        end else if (sck_fall && s.bit_cnt == LAST_FALL_IDX) begin
          n.sdo = 1'b1;  // [R13]
          pop = 1'b1;
          restart = 1'b1;
          n.state = SER_IDLE;
        end else if (sck_fall) begin
          n.sdo = s.shreg[WORD_BITS-1];  // [R11]
          n.shreg = {s.shreg[WORD_BITS-2:0], 1'b1};
          n.bit_cnt = s.bit_cnt + 5'h1;
        end
      end
      default: begin
        n.state = SER_IDLE;
      end
    endcase
    // Counter clears per result so nothing carries into the next one
    if (restart || push)
      n.tick_cnt = '0;  // [R5] [R13]
    else if (conv_tick && s.tick_cnt != CONV_DONE)
      n.tick_cnt = s.tick_cnt + 15'h1;  // [R3] [R15]
  end

  // State register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
      s.cs_s1 <= 1'b1;
      s.cs_s2 <= 1'b1;
      s.cs_d <= 1'b1;
      s.sdo <= 1'b1;
      s.sdo_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs
  assign SDO = s.sdo;
  assign SDO_OE_N = s.sdo_oe_n;
  assign EXT_CLOCK_MODE = s.ext_mode;
  assign CONV_STALLED = (s.tick_cnt == CONV_DONE) && !push_ready;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // Tick spacing is only meaningful after one clean oscillator tick, so an
  // external clock period or a select change re-arms the measurement
  logic [9:0] gap_ff;
  logic gap_ok_ff;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      gap_ff <= '0;
      gap_ok_ff <= 1'b0;
    end else if (s.ext_mode || f0_edge) begin
      gap_ff <= '0;
      gap_ok_ff <= 1'b0;
    end else if (conv_tick) begin
      gap_ff <= '0;
      gap_ok_ff <= 1'b1;
    end else begin
      gap_ff <= gap_ff + 10'h1;
    end
  end

  sequence s_load;
    s.state == SER_IDLE && cs_low && sck_fall && fifo_valid;
  endsequence
  sequence s_last_fall;
    s.state == SER_SHIFT && !cs_rise && sck_fall
      && s.bit_cnt == LAST_FALL_IDX;
  endsequence

  a_osc_tick_gap: assert property ( // [R1]
    (conv_tick && !s.ext_mode && !f0_edge && gap_ok_ff)
      |-> gap_ff == osc_div - 10'h1)
    else $error("oscillator tick spacing wrong");
  a_ext_entry: assert property (f0_edge |=> s.ext_mode) // [R3]
    else $error("toggling select pin not taken as clock");
  a_result_ratio: assert property (push |-> s.tick_cnt == CONV_DONE) // [R3]
    else $error("result pushed before full tick count");
  a_fresh_start: assert property (push |=> s.tick_cnt == 15'h0) // [R5]
    else $error("conversion count not cleared after result");
  a_clamp_range: assert property ( // [R8] [R9]
    push |-> (adcrc_code(ANALOG_CODE) <= {2'b11, OVER_CLAMP})
      && (adcrc_code(ANALOG_CODE) >= {2'b01, UNDER_CLAMP}
      || adcrc_code(ANALOG_CODE) >= {2'b10, 20'h0}))
    else $error("result code outside clamp limits");
  a_dummy_first: assert property (s_load |=> s.sdo == 1'b0) // [R6]
    else $error("dummy bit not low on first fall");
  a_end_high: assert property ( // [R13]
    s_last_fall |=> s.sdo && s.state == SER_IDLE && s.tick_cnt == 15'h0)
    else $error("24th fall did not end word high");
  a_abort_restart: assert property ( // [R14]
    (s.state == SER_SHIFT && cs_rise) |=> s.state == SER_IDLE ##1 s.sdo_oe_n)
    else $error("chip select rise did not abort readout");
  a_eoc_shown: assert property ( // [R12]
    (s.state == SER_IDLE && !fifo_valid && cs_low)[*2] |-> s.sdo)
    else $error("done flag low without a result");
endmodule // adcrc_top

`default_nettype wire

// file: verif/adcrc_host.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------
// Host reading results
// --------------------
module adcrc_host (
  // Clock
  input wire logic CLK_SYS,
  // Serial data from the converter
  input wire logic SDO,
  input wire logic SDO_OE_N,
  // Host driven pins
  output logic CS_N,
  output logic SCK,
  output logic RATE_SELECT_CLOCK_IN
);
  // Idle: deselected, clock high, 60 Hz oscillator
  initial begin
    CS_N = 1'b1;
    SCK = 1'b1;
    RATE_SELECT_CLOCK_IN = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  // Gapless clock, levels of 4 cycles so the pin sync never misses one
  task automatic ext_clock(input int rises);
    repeat (rises) begin
      @(posedge CLK_SYS);
      RATE_SELECT_CLOCK_IN <= 1'b1;
      wait_cyc(4);
      RATE_SELECT_CLOCK_IN <= 1'b0;
      wait_cyc(3);
    end
  endtask

  task automatic set_pin(input logic v);
    @(posedge CLK_SYS);
    RATE_SELECT_CLOCK_IN <= v;
  endtask

  // Clock falls while deselected must be ignored
  task automatic sck_only(input int falls);
    repeat (falls) begin
      @(posedge CLK_SYS);
      SCK <= 1'b0;
      wait_cyc(4);
      SCK <= 1'b1;
      wait_cyc(3);
    end
  endtask

  // From 1 to 23 falls aborts the transfer; 0 falls only samples the flag
  task automatic read_word(input int falls, output logic [23:0] w,
                           output logic tail);
    w = 24'h0;
    @(posedge CLK_SYS);
    CS_N <= 1'b0;
    wait_cyc(6);
    w[23] = SDO;
    for (int k = 1; k <= falls; k++) begin
      SCK <= 1'b0;
      wait_cyc(4);
      SCK <= 1'b1;
      wait_cyc(4);
      if (k < 24) begin
        w[23-k] = SDO;
      end
    end
    tail = SDO;
    CS_N <= 1'b1;
    wait_cyc(6);
  endtask

  // Cycles until the done flag drops with the chip selected
  task automatic wait_done(output int cyc);
    cyc = 0;
    @(posedge CLK_SYS);
    CS_N <= 1'b0;
    wait_cyc(6);
    while (SDO !== 1'b0 && cyc < 20000) begin
      @(posedge CLK_SYS);
      cyc++;
    end
    CS_N <= 1'b1;
    wait_cyc(6);
  endtask
endmodule // adcrc_host
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adcrc_pkg::*;
  typedef struct {logic [22:0] code; logic [23:0] word;} adcrc_row_t;
  localparam int TICKS = 16;
  logic clk_sys, rst_n, cs_n, sck, pin, sdo, sdo_oe_n, ext_mode, stalled;
  logic signed [IN_BITS-1:0] analog_code;
  logic [23:0] word;
  logic tail;
  int failures, tests_run, n;
  adcrc_row_t rows [12];

  adcrc_top #(.CONV_TICKS(TICKS), .FSEL_IDLE_CYCLES(64)) dut_u (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .RATE_SELECT_CLOCK_IN(pin),
    .ANALOG_CODE(analog_code), .CS_N(cs_n), .SCK(sck), .SDO(sdo),
    .SDO_OE_N(sdo_oe_n), .EXT_CLOCK_MODE(ext_mode),
    .CONV_STALLED(stalled));
  adcrc_host host_u (.CLK_SYS(clk_sys), .SDO(sdo), .SDO_OE_N(sdo_oe_n),
    .CS_N(cs_n), .SCK(sck), .RATE_SELECT_CLOCK_IN(pin));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog, about twice the expected run
  initial begin
    repeat (90000) @(posedge clk_sys);
    failures++;
    $display("FAIL %0t watchdog", $time);
    give_verdict();
  end

  // ----------------------------------
  // Coding table, reset and hard cases
  // ----------------------------------
  initial begin
    rst_n = 1'b0;
    analog_code = '0;
    rows = '{'{23'h000000, 24'h200000}, '{23'h000001, 24'h200001},
      '{23'h080000, 24'h280000}, '{23'h0fffff, 24'h2fffff},
      '{23'h100000, 24'h300000}, '{23'h100001, 24'h300001},
      '{23'h11ffff, 24'h31ffff}, '{23'h3fffff, 24'h31ffff},
      '{23'h7fffff, 24'h1fffff}, '{23'h7e0001, 24'h1e0001},
      '{23'h7e0000, 24'h1e0000}, '{23'h400000, 24'h1e0000}};
    repeat (2) @(posedge clk_sys);
    check(24'(sdo_oe_n), 24'h1, "oe in reset");
    check(24'({sdo, ext_mode, stalled}), 24'h4, "reset outs");
    rst_n <= 1'b1;
    host_u.read_word(0, word, tail);
    check(24'(word[23]), 24'h1, "busy flag");
    // Back-to-back rows at differing inputs
    foreach (rows[i]) begin
      analog_code <= signed'(rows[i].code);
      host_u.ext_clock(TICKS + 4);
      check(24'(ext_mode), 24'h1, "ext mode");
      host_u.read_word(24, word, tail);
      check(word, rows[i].word, "row");
      check(24'(tail), 24'h1, "tail");
    end
    // Abort mid-word pops it and restarts a 60 Hz conversion
    host_u.ext_clock(TICKS + 4);
    host_u.wait_cyc(80);
    check(24'(ext_mode), 24'h0, "osc mode");
    host_u.sck_only(8);
    host_u.read_word(0, word, tail);
    check(24'(word[23]), 24'h0, "falls ignored");
    host_u.read_word(5, word, tail);
    check(24'(sdo_oe_n), 24'h1, "oe off");
    host_u.read_word(0, word, tail);
    check(24'(word[23]), 24'h1, "abort pop");
    host_u.wait_done(n);
    check(24'(n >= 12150 && n <= 13030), 24'h1, "60 Hz span");
    host_u.set_pin(1'b1);
    host_u.wait_cyc(100);
    host_u.read_word(24, word, tail);
    host_u.wait_done(n);
    check(24'(n >= 14590 && n <= 15640), 24'h1, "50 Hz span");
    // Fill the result queue until it refuses, then drain it
    host_u.set_pin(1'b0);
    analog_code <= 23'sh000123;
    host_u.ext_clock(33 * TICKS + 8);
    check(24'(stalled), 24'h1, "stall");
    n = 0;
    while (n < 40) begin
      host_u.read_word(24, word, tail);
      if (word[23] !== 1'b0)
        break;
      if (n == 0)
        check(24'(stalled), 24'h0, "unstall");
      else
        check(word, 24'h200123, "queued word");
      n++;
    end
    check(24'(n == 32 || n == 33), 24'h1, "queue depth");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
